/* File: hdl/info_query_command_handler.sv */
// How it works
// - Mode 0x01 returns word 1 when parameter's slot holds valid ECC key, else 0.
// - Mode 0x02 with zero parameter returns zero, zero, status byte 1, byte 0.
// - Status byte 0 bits 7,6,5 are the three scratch-buffer validity flags.
// - Status byte 0 bit 4 is scratch source, bits 3:0 its slot.
// - Status byte 1: valid bit 7, auth slot 6:3, auth ok bit 2, zeros.
// - Mode 0x03 parameter 2 drives output low, parameter 3 drives it high.
// - The general-purpose output comes out of reset low.
// - Output writes are refused unless the single-wire variant is configured.
// - Good output write echoes the level in a word; failure gives one error byte.
// - Mode 0x04 returns word 1 when latch is set and boot check enabled, else 0; errors one byte.
// - Latch sets only on successful boot check, enabled; it authorizes slot 0.
// - Configuration is write-any; slots stay writable until individually locked.
// - Opcode 0x17 locks a lockable, unlocked slot until reset; else error.
`timescale 1ns/1ps
module info_query_command_handler #(
   parameter int          SLOTS      = 16,
   parameter logic [15:0] REVISION_ID = 16'h0001  // Arbitrary value
) (
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // Command port
   input  wire logic             cmdValid,
   input  wire logic [7:0]       cmdOpcode,
   input  wire logic [7:0]       cmdMode,
   input  wire logic [15:0]      cmdParam,
   output logic                  rspValid,
   output logic [2:0]            rspLen,
   output logic [31:0]           rspData,
   // Device state seen by the query
   input  wire logic [SLOTS-1:0] eccKeyValid,
   input  wire logic             scratchNoAuthCodeFlag,
   input  wire logic             scratchKeygenDataFlag,
   input  wire logic             scratchDigestDataFlag,
   input  wire logic             scratchSourceFlag,
   input  wire logic [3:0]       scratchSlotId,
   input  wire logic             scratchValidFlag,
   input  wire logic [3:0]       authorizingSlotId,
   input  wire logic             authorizationValidFlag,
   input  wire logic             bootVerifyOk,
   // Outputs to the rest of the device
   output logic                  gpioOut,
   output logic                  primaryKeyAuthorized,
   output logic [SLOTS-1:0]      slotWriteAllow,
   // Register port
   input  wire logic [7:0]       regAddr,
   input  wire logic [31:0]      regWdata,
   input  wire logic             regWr,
   input  wire logic             regRd,
   output logic [31:0]           regRdata
);

   // Configuration and lockable mask
   logic [1:0]       config_r;
   logic [1:0]       config_nxt;
   logic [SLOTS-1:0] lockable_r;
   logic [SLOTS-1:0] lockable_nxt;
   logic [31:0]      regRdata_r;
   logic [31:0]      regRdata_nxt;

   // Command state
   logic             rspValid_r;
   logic             rspValid_nxt;
   logic [2:0]       rspLen_r;
   logic [2:0]       rspLen_nxt;
   logic [31:0]      rspData_r;
   logic [31:0]      rspData_nxt;
   logic             gpio_r;
   logic             gpio_nxt;
   logic             latch_r;
   logic             latch_nxt;

   logic             singleWire;
   logic             bootEn;
   logic [7:0]       statusByte0;
   logic [7:0]       statusByte1;
   logic             keyHit;
   logic             lockReq;
   logic             lockOk;
   logic [SLOTS-1:0] locked;
   logic             isInfo;
   logic             isLockCmd;

   assign singleWire = config_r[info_query_pkg::CFG_SINGLE_WIRE];
   assign bootEn     = config_r[info_query_pkg::CFG_BOOT_EN];
   assign keyHit     = eccKeyValid[cmdParam[3:0]];
   assign isInfo     = cmdValid && (cmdOpcode == info_query_pkg::OP_INFO);
   assign isLockCmd  = cmdValid && (cmdOpcode == info_query_pkg::OP_LOCK);
   // Decoded outside the command process so the bank's answer never loops back into it
   assign lockReq    = isLockCmd &&
                       cmdMode[7:6] == info_query_pkg::LOCK_MODE_TOP &&
                       cmdMode[1:0] == info_query_pkg::LOCK_MODE_TAG &&
                       cmdParam == info_query_pkg::PARAM_ZERO;

   // Packed device-state bytes
   always_comb begin
      statusByte0 = '0;
      statusByte0[info_query_pkg::SB0_NO_AUTH] = scratchNoAuthCodeFlag;
      statusByte0[info_query_pkg::SB0_KEYGEN]  = scratchKeygenDataFlag;
      statusByte0[info_query_pkg::SB0_DIGEST]  = scratchDigestDataFlag;
      statusByte0[info_query_pkg::SB0_SOURCE]  = scratchSourceFlag;
      statusByte0[3:0]                         = scratchSlotId;
      statusByte1 = '0;
      statusByte1[info_query_pkg::SB1_VALID]   = scratchValidFlag;
      statusByte1[info_query_pkg::SB1_AUTH_LSB +: 4] = authorizingSlotId;
      statusByte1[info_query_pkg::SB1_AUTH_OK] = authorizationValidFlag;
      statusByte1[1:0] = info_query_pkg::SB1_UNUSED;
   end

   slot_lock_bank #(
      .SLOTS    (SLOTS)
   ) u_locks (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .lockReq  (lockReq),
      .lockSlot (cmdMode[info_query_pkg::LOCK_SLOT_LSB +: 4]),
      .lockable (lockable_r),
      .lockOk   (lockOk),
      .locked   (locked)
   );

   // Command decode; gpio moves only on a fully accepted command, the latch on any enabled boot check
   always_comb begin
      rspValid_nxt = cmdValid;
      rspLen_nxt   = rspLen_r;
      rspData_nxt  = rspData_r;
      gpio_nxt     = gpio_r;
      latch_nxt    = latch_r | (bootVerifyOk & bootEn);
      if (cmdValid) begin
         rspLen_nxt  = info_query_pkg::RSP_LEN_BYTE;
         rspData_nxt = {24'h000000, info_query_pkg::ERR_PARSE};
      end
      if (isInfo) begin
         case (cmdMode)
            info_query_pkg::MODE_REVISION: begin
               if (cmdParam == info_query_pkg::PARAM_ZERO) begin
                  rspLen_nxt  = info_query_pkg::RSP_LEN_WORD;
                  rspData_nxt = {16'h0000, REVISION_ID};
               end
            end
            info_query_pkg::MODE_KEY_CHECK: begin
               if (cmdParam[15:4] == 12'h000) begin
                  rspLen_nxt  = info_query_pkg::RSP_LEN_WORD;
                  rspData_nxt = {31'h00000000, keyHit};
               end
            end
            info_query_pkg::MODE_STATE: begin
               if (cmdParam == info_query_pkg::PARAM_ZERO) begin
                  rspLen_nxt  = info_query_pkg::RSP_LEN_WORD;
                  rspData_nxt = {16'h0000, statusByte1, statusByte0};
               end
            end
            info_query_pkg::MODE_GPIO: begin
               if (!singleWire) begin
                  rspData_nxt = {24'h000000, info_query_pkg::ERR_EXEC};
               end else if (cmdParam == info_query_pkg::PARAM_GPIO_LOW ||
                            cmdParam == info_query_pkg::PARAM_GPIO_HI) begin
                  gpio_nxt    = cmdParam[0];
                  rspLen_nxt  = info_query_pkg::RSP_LEN_WORD;
                  rspData_nxt = {31'h00000000, cmdParam[0]};
               end
            end
            info_query_pkg::MODE_LATCH: begin
               if (cmdParam == info_query_pkg::PARAM_ZERO) begin
                  rspLen_nxt  = info_query_pkg::RSP_LEN_WORD;
                  rspData_nxt = {31'h00000000, latch_r & bootEn};
               end
            end
            default: begin
               rspLen_nxt = info_query_pkg::RSP_LEN_BYTE;
            end
         endcase
      end
      if (lockReq) begin
         rspData_nxt = lockOk ? {24'h000000, info_query_pkg::RSP_OK_BYTE}
                              : {24'h000000, info_query_pkg::ERR_EXEC};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rspValid_r <= 1'b0;
         rspLen_r   <= info_query_pkg::RSP_LEN_BYTE;
         rspData_r  <= '0;
         gpio_r     <= 1'b0;
         latch_r    <= 1'b0;
      end else begin
         rspValid_r <= rspValid_nxt;
         rspLen_r   <= rspLen_nxt;
         rspData_r  <= rspData_nxt;
         gpio_r     <= gpio_nxt;
         latch_r    <= latch_nxt;
      end
   end

   // Register port; configuration is write-any, but a locked slot stays locked
   always_comb begin
      config_nxt   = config_r;
      lockable_nxt = lockable_r;
      regRdata_nxt = '0;
      if (regWr) begin
         case (regAddr)
            info_query_pkg::REG_CONFIG:   config_nxt   = regWdata[1:0];
            info_query_pkg::REG_LOCKABLE: lockable_nxt = regWdata[SLOTS-1:0];
            default: ;
         endcase
      end
      if (regRd) begin
         case (regAddr)
            info_query_pkg::REG_CONFIG:   regRdata_nxt[1:0] = config_r;
            info_query_pkg::REG_LOCKABLE: regRdata_nxt[SLOTS-1:0] = lockable_r;
            info_query_pkg::REG_STATUS: begin
               regRdata_nxt[info_query_pkg::ST_GPIO]  = gpio_r;
               regRdata_nxt[info_query_pkg::ST_LATCH] = latch_r;
               regRdata_nxt[info_query_pkg::ST_LOCKED_LSB +: SLOTS] = locked;
            end
            default: regRdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         config_r   <= info_query_pkg::CONFIG_RESET;
         lockable_r <= info_query_pkg::LOCKABLE_RESET[SLOTS-1:0];
         regRdata_r <= '0;
      end else begin
         config_r   <= config_nxt;
         lockable_r <= lockable_nxt;
         regRdata_r <= regRdata_nxt;
      end
   end

   assign rspValid             = rspValid_r;
   assign rspLen               = rspLen_r;
   assign rspData              = rspData_r;
   assign gpioOut              = gpio_r;
   assign regRdata             = regRdata_r;
   // Slot 0 is authorized only through a completed boot check
   assign primaryKeyAuthorized = latch_r & bootEn;
   // Access policies are fixed; only the per-slot lock removes write access
   assign slotWriteAllow       = ~locked;

   a_gpio_reset_low: assert property (@(posedge sys_clk)
      !nrst |=> !gpioOut)
      else $error("gpio not low after reset");

   a_gpio_i2c_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      (isInfo && cmdMode == info_query_pkg::MODE_GPIO && !singleWire)
      |=> $stable(gpioOut) && rspLen == info_query_pkg::RSP_LEN_BYTE)
      else $error("gpio write acted on two-wire variant");

   a_gpio_echo_high: assert property (@(posedge sys_clk) disable iff (!nrst)
      (isInfo && cmdMode == info_query_pkg::MODE_GPIO && singleWire &&
       cmdParam == info_query_pkg::PARAM_GPIO_HI)
      |=> gpioOut && rspValid && rspData == 32'h00000001 &&
          rspLen == info_query_pkg::RSP_LEN_WORD)
      else $error("gpio high write not echoed");

   a_key_check_word: assert property (@(posedge sys_clk) disable iff (!nrst)
      (isInfo && cmdMode == info_query_pkg::MODE_KEY_CHECK && cmdParam[15:4] == 12'h000)
      |=> rspValid && rspLen == info_query_pkg::RSP_LEN_WORD &&
          rspData == {31'h00000000, $past(keyHit)})
      else $error("key check answer wrong");

   a_state_word: assert property (@(posedge sys_clk) disable iff (!nrst)
      (isInfo && cmdMode == info_query_pkg::MODE_STATE &&
       cmdParam == info_query_pkg::PARAM_ZERO)
      |=> rspValid && rspLen == info_query_pkg::RSP_LEN_WORD &&
          rspData[31:16] == 16'h0000 && rspData[9:8] == 2'h0 &&
          rspData[15:8] == $past({scratchValidFlag, authorizingSlotId,
                                  authorizationValidFlag, 2'b00}) &&
          rspData[7:0] == $past({scratchNoAuthCodeFlag, scratchKeygenDataFlag,
                                 scratchDigestDataFlag, scratchSourceFlag, scratchSlotId}))
      else $error("device state word wrong");

   a_latch_read: assert property (@(posedge sys_clk) disable iff (!nrst)
      (isInfo && cmdMode == info_query_pkg::MODE_LATCH &&
       cmdParam == info_query_pkg::PARAM_ZERO)
      |=> rspLen == info_query_pkg::RSP_LEN_WORD &&
          rspData == {31'h00000000, $past(primaryKeyAuthorized)})
      else $error("latch read wrong");

   a_bad_mode_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
      (isInfo && cmdMode > info_query_pkg::MODE_LATCH)
      |=> rspValid && rspLen == info_query_pkg::RSP_LEN_BYTE && $stable(gpioOut) &&
          $stable(locked))
      else $error("unsupported mode not refused");

   a_lock_refused: assert property (@(posedge sys_clk) disable iff (!nrst)
      (lockReq && !lockOk)
      |=> rspLen == info_query_pkg::RSP_LEN_BYTE && rspData[7:0] != 8'h00 &&
          $stable(locked))
      else $error("illegal slot lock not refused");

   a_gpio_echo_low: assert property (@(posedge sys_clk) disable iff (!nrst)
      (isInfo && cmdMode == info_query_pkg::MODE_GPIO && singleWire &&
       cmdParam == info_query_pkg::PARAM_GPIO_LOW)
      |=> !gpioOut && rspValid && rspLen == info_query_pkg::RSP_LEN_WORD &&
          rspData == 32'h00000000)
      else $error("gpio low write not echoed");

   a_lock_taken: assert property (@(posedge sys_clk) disable iff (!nrst)
      lockOk
      |=> rspValid && rspLen == info_query_pkg::RSP_LEN_BYTE &&
          rspData == 32'h00000000 && locked != $past(locked))
      else $error("legal slot lock not taken");

   a_bad_opcode_error: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cmdValid && cmdOpcode != info_query_pkg::OP_INFO &&
       cmdOpcode != info_query_pkg::OP_LOCK)
      |=> rspValid && rspLen == info_query_pkg::RSP_LEN_BYTE &&
          rspData == {24'h000000, info_query_pkg::ERR_PARSE} && $stable(gpioOut))
      else $error("unknown opcode not refused");

endmodule // info_query_command_handler

/* File: hdl/slot_lock_bank.sv */
`timescale 1ns/1ps
module slot_lock_bank #(
   parameter int SLOTS = 16
) (
   input  wire logic                     sys_clk,
   input  wire logic                     nrst,
   input  wire logic                     lockReq,
   input  wire logic [$clog2(SLOTS)-1:0] lockSlot,
   input  wire logic [SLOTS-1:0]         lockable,
   output logic                          lockOk,
   output logic [SLOTS-1:0]              locked
);
   logic [SLOTS-1:0] locked_r;
   logic [SLOTS-1:0] locked_nxt;

   always_comb begin
      lockOk     = lockReq && lockable[lockSlot] && !locked_r[lockSlot];
      locked_nxt = locked_r;
      if (lockOk) begin
         locked_nxt[lockSlot] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         locked_r <= '0;
      end else begin
         locked_r <= locked_nxt;
      end
   end

   assign locked = locked_r;

   // A lock is undone only by reset
   a_lock_permanent: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($past(locked_r) & ~locked_r) == '0)
      else $error("slot lock bit cleared");

endmodule // slot_lock_bank

/* File: pkg/info_query_pkg.sv */
package info_query_pkg;

   // Command opcodes and modes
   localparam logic [7:0]  OP_INFO        = 8'h30;
   localparam logic [7:0]  OP_LOCK        = 8'h17;
   localparam logic [7:0]  MODE_REVISION  = 8'h00;
   localparam logic [7:0]  MODE_KEY_CHECK = 8'h01;
   localparam logic [7:0]  MODE_STATE     = 8'h02;
   localparam logic [7:0]  MODE_GPIO      = 8'h03;
   localparam logic [7:0]  MODE_LATCH     = 8'h04;

   // Parameter words
   localparam logic [15:0] PARAM_ZERO     = 16'h0000;
   localparam logic [15:0] PARAM_GPIO_LOW = 16'h0002;
   localparam logic [15:0] PARAM_GPIO_HI  = 16'h0003;

   // Slot-lock mode layout: 8'b00ssss10
   localparam int          LOCK_SLOT_LSB  = 2;
   localparam logic [1:0]  LOCK_MODE_TAG  = 2'h2;
   localparam logic [1:0]  LOCK_MODE_TOP  = 2'h0;

   // Status byte 0 field positions
   localparam int          SB0_NO_AUTH    = 7;
   localparam int          SB0_KEYGEN     = 6;
   localparam int          SB0_DIGEST     = 5;
   localparam int          SB0_SOURCE     = 4;
   // Status byte 1 field positions
   localparam int          SB1_VALID      = 7;
   localparam int          SB1_AUTH_LSB   = 3;
   localparam int          SB1_AUTH_OK    = 2;
   localparam logic [1:0]  SB1_UNUSED     = 2'h0;

   // Response sizes and codes
   localparam logic [2:0]  RSP_LEN_WORD   = 3'h4;
   localparam logic [2:0]  RSP_LEN_BYTE   = 3'h1;
   localparam logic [7:0]  RSP_OK_BYTE    = 8'h00;
   localparam logic [7:0]  ERR_PARSE      = 8'h03;
   localparam logic [7:0]  ERR_EXEC       = 8'h0F;

   // Register offsets
   localparam logic [7:0]  REG_CONFIG     = 8'h00;
   localparam logic [7:0]  REG_LOCKABLE   = 8'h04;
   localparam logic [7:0]  REG_STATUS     = 8'h08;

   // CONFIG fields and reset values
   localparam int          CFG_SINGLE_WIRE = 0;
   localparam int          CFG_BOOT_EN     = 1;
   localparam logic [1:0]  CONFIG_RESET    = 2'h3;
   localparam logic [15:0] LOCKABLE_RESET  = 16'hBD7C;

   // STATUS fields
   localparam int          ST_GPIO        = 0;
   localparam int          ST_LATCH       = 1;
   localparam int          ST_LOCKED_LSB  = 16;

endpackage

/* File: verif/host_cmd_model.sv */
`timescale 1ns/1ps
module host_cmd_model (
   input  wire logic        sys_clk,
   output logic             cmdValid,
   output logic [7:0]       cmdOpcode,
   output logic [7:0]       cmdMode,
   output logic [15:0]      cmdParam
);
   initial begin
      cmdValid  = 1'b0;
      cmdOpcode = 8'h00;
      cmdMode   = 8'h00;
      cmdParam  = 16'h0000;
   end

   // One-cycle strobe; fields held until the taking edge has passed
   task automatic send(input logic [7:0] op, input logic [7:0] md, input logic [15:0] pr);
      @(posedge sys_clk);
      cmdValid  <= 1'b1;
      cmdOpcode <= op;
      cmdMode   <= md;
      cmdParam  <= pr;
      @(posedge sys_clk);
      cmdValid  <= 1'b0;
      cmdParam  <= ~pr;
   endtask

   task automatic keyCheck(input logic [3:0] slot);
      send(info_query_pkg::OP_INFO, info_query_pkg::MODE_KEY_CHECK, {12'h000, slot});
   endtask

   task automatic deviceState();
      send(info_query_pkg::OP_INFO, info_query_pkg::MODE_STATE, info_query_pkg::PARAM_ZERO);
   endtask

   task automatic gpioWrite(input logic lvl);
      send(info_query_pkg::OP_INFO, info_query_pkg::MODE_GPIO,
           lvl ? info_query_pkg::PARAM_GPIO_HI : info_query_pkg::PARAM_GPIO_LOW);
   endtask

   task automatic latchRead();
      send(info_query_pkg::OP_INFO, info_query_pkg::MODE_LATCH, info_query_pkg::PARAM_ZERO);
   endtask
endmodule // host_cmd_model

/* File: verif/info_query_command_handler_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin nMismatch++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module info_query_command_handler_test;
   localparam logic [15:0] REV = 16'h00A5; // Arbitrary value
   logic sys_clk, nrst, cmdValid, rspValid, gpioOut, primaryKeyAuthorized;
   logic [7:0]  cmdOpcode, cmdMode, regAddr;
   logic [15:0] cmdParam, eccKeyValid, slotWriteAllow;
   logic [2:0]  rspLen;
   logic [31:0] rspData, regWdata, regRdata, seed, r;
   logic        sNoAuth, sKeygen, sDigest, sSource, sValid, aValid, bootOk, regWr, regRd, rdPend;
   logic [3:0]  sSlot, aSlot;
   logic [34:0] rspQ[$];
   logic [31:0] rdQ[$];
   logic [31:0] rdExp;
   logic [34:0] rExp;
   int nMismatch, numChecks;

   info_query_command_handler #(.SLOTS(16), .REVISION_ID(REV)) uut (
      .sys_clk(sys_clk), .nrst(nrst), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
      .cmdMode(cmdMode), .cmdParam(cmdParam), .rspValid(rspValid), .rspLen(rspLen),
      .rspData(rspData), .eccKeyValid(eccKeyValid), .scratchNoAuthCodeFlag(sNoAuth),
      .scratchKeygenDataFlag(sKeygen), .scratchDigestDataFlag(sDigest),
      .scratchSourceFlag(sSource), .scratchSlotId(sSlot), .scratchValidFlag(sValid),
      .authorizingSlotId(aSlot), .authorizationValidFlag(aValid), .bootVerifyOk(bootOk),
      .gpioOut(gpioOut), .primaryKeyAuthorized(primaryKeyAuthorized),
      .slotWriteAllow(slotWriteAllow), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

   host_cmd_model host (.sys_clk(sys_clk), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
      .cmdMode(cmdMode), .cmdParam(cmdParam));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   task automatic expRsp(input logic [2:0] len, input logic [31:0] d);
      rspQ.push_back({len, d});
   endtask

   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge sys_clk);
      regWr    <= 1'b0;
   endtask

   task automatic regRead(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      regAddr <= a;
      regRd   <= 1'b1;
      rdQ.push_back(e);
      @(posedge sys_clk);
      regRd   <= 1'b0;
   endtask

   task automatic settle();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic final_report();
      if (nMismatch == 0 && numChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Answers are matched in issue order against the oldest note
   always @(posedge sys_clk) begin
      if (rspValid === 1'b1) begin
         if (rspQ.size() == 0) `CHK(rspValid, 1'b0)
         else begin
            rExp = rspQ.pop_front();
            `CHK({rspLen, rspData}, rExp)
         end
      end
      if (rdPend === 1'b1 && rdQ.size() > 0) begin
         rdExp = rdQ.pop_front();
         `CHK(regRdata, rdExp)
      end
      rdPend <= regRd;
   end

   initial begin
      seed = 32'hD815;
      nrst = 1'b0;
      {regWr, regRd, bootOk, regAddr, regWdata} = '0;
      {sNoAuth, sKeygen, sDigest, sSource, sValid, aValid, sSlot, aSlot} = '0;
      eccKeyValid = 16'h0000;
      nMismatch = 0;
      numChecks = 0;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      settle();
      `CHK(gpioOut, 1'b0)
      `CHK(slotWriteAllow, 16'hFFFF)
      regRead(8'h00, 32'h0000_0003);
      regRead(8'h04, 32'h0000_BD7C);
      regWrite(8'h08, 32'hFFFF_FFFF);
      regRead(8'h08, 32'h0000_0000);
      regRead(8'h0C, 32'h0000_0000);
      expRsp(3'h4, {16'h0000, REV});
      host.send(8'h30, 8'h00, 16'h0000);
      r = rnd();
      eccKeyValid <= r[15:0];
      for (int s = 0; s < 16; s++) begin
         expRsp(3'h4, {31'h0, r[s]});
         host.keyCheck(s[3:0]);
      end
      expRsp(3'h1, 32'h03);
      host.send(8'h30, 8'h01, 16'h0010);
      repeat (4) begin
         r = rnd();
         {sNoAuth, sKeygen, sDigest, sSource, sSlot} <= r[15:8];
         {sValid, aSlot, aValid} <= r[7:2];
         expRsp(3'h4, {16'h0000, r[7:2], 2'b00, r[15:8]});
         host.deviceState();
      end
      expRsp(3'h1, 32'h03);
      host.send(8'h30, 8'h02, 16'h0001);
      expRsp(3'h4, 32'h1);
      host.gpioWrite(1'b1);
      settle();
      `CHK(gpioOut, 1'b1)
      expRsp(3'h1, 32'h03);
      host.send(8'h30, 8'h03, 16'h0004);
      settle();
      `CHK(gpioOut, 1'b1)
      regWrite(8'h00, 32'h2);
      expRsp(3'h1, 32'h0F);
      host.gpioWrite(1'b0);
      settle();
      `CHK(gpioOut, 1'b1)
      regWrite(8'h00, 32'h3);
      expRsp(3'h4, 32'h0);
      host.gpioWrite(1'b0);
      settle();
      `CHK(gpioOut, 1'b0)
      expRsp(3'h4, 32'h0);
      host.latchRead();
      settle();
      `CHK(primaryKeyAuthorized, 1'b0)
      @(posedge sys_clk) bootOk <= 1'b1;
      @(posedge sys_clk) bootOk <= 1'b0;
      expRsp(3'h4, 32'h1);
      host.latchRead();
      settle();
      `CHK(primaryKeyAuthorized, 1'b1)
      expRsp(3'h1, 32'h03);
      host.send(8'h30, 8'h04, 16'h0001);
      regWrite(8'h00, 32'h1);
      expRsp(3'h4, 32'h0);
      host.latchRead();
      settle();
      `CHK(primaryKeyAuthorized, 1'b0)
      regWrite(8'h00, 32'h3);
      expRsp(3'h1, 32'h00);
      host.send(8'h17, 8'h16, 16'h0000);
      settle();
      `CHK(slotWriteAllow, 16'hFFDF)
      expRsp(3'h1, 32'h0F);
      host.send(8'h17, 8'h16, 16'h0000);
      expRsp(3'h1, 32'h0F);
      host.send(8'h17, 8'h02, 16'h0000);
      expRsp(3'h1, 32'h00);
      host.send(8'h17, 8'h3E, 16'h0000);
      settle();
      `CHK(slotWriteAllow, 16'h7FDF)
      regRead(8'h08, 32'h8020_0002);
      expRsp(3'h1, 32'h03);
      host.send(8'h31, 8'h00, 16'h0000);
      expRsp(3'h1, 32'h03);
      host.send(8'h30, 8'h05, 16'h0000);
      for (int i = 0; i < 20 && (rspQ.size() + rdQ.size()) > 0; i++) @(posedge sys_clk);
      if ((rspQ.size() + rdQ.size()) > 0) nMismatch++;
      final_report();
   end
endmodule // info_query_command_handler_test
